//--- core/crs_sequencer.sv
// Chip reset sequencer merging four reset sources into internal reset.
`timescale 1ns/1ps

// Contract
// - Any of four sources asserts chip reset.
// - Usable supply, reset drives status low, timer.
// - Hold reset until pin, oscillator, count, flash.
// - Status high the cycle after release; brown-out waits recovery.
// - After release, processor fetches at address zero.
// - Registers hold reset values at release.
module crs_sequencer #(
  parameter int WAKE_CYCLES = crs_pkg::WAKE_CYCLES_DEFAULT
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire crs_pkg::crs_src_t SRC,
  input wire crs_pkg::crs_cond_t COND,
  output logic SYS_RESET_N,
  output logic RESET_STATUS_OUT,
  output logic [31:0] FETCH_ADDR,
  output logic FETCH_START
);

  localparam int CW = (WAKE_CYCLES < 2) ? 1 : $clog2(WAKE_CYCLES + 1);
  localparam logic [CW-1:0] WAKE_LAST = CW'(WAKE_CYCLES - 1);

  // Refuse a wake count of zero.
  if (WAKE_CYCLES < 1) begin : g_chk
    $error("WAKE_CYCLES must be at least one.");
  end

  // All state of the sequencer in one packed struct.
  typedef struct packed {
    crs_pkg::crs_state_t state; // Sequencer phase.
    logic [CW-1:0] count;       // Wake-up timer.
    logic sys_reset_n;          // Internal reset, active low.
    logic rstat;                // Reset-status pin level.
    logic [31:0] fetch_addr;    // Start address handed to the core.
    logic fetch_start;          // One-cycle pulse at reset release.
  } crs_st_t;

  crs_st_t st;
  crs_st_t next_st;
  logic any_src;    // Some source is requesting reset.
  logic bod_held;   // Brown-out still seen or recently seen.
  logic ready;      // Pin free, oscillator and flash ready; supply is checked apart.

  // Brown-out recovery tracking.
  crs_hold_filter #(
    .STAGES(crs_pkg::SYNC_STAGES)
  ) u_bod (
    .clk(CLK),
    .arst_n(ARST_N),
    .level_in(SRC.brownout),
    .held(bod_held)
  );

  // Any single source suffices to request reset.
  assign any_src = SRC.pin | SRC.watchdog | SRC.poweron | SRC.brownout;
  assign ready = ~SRC.pin & COND.osc_ok & COND.flash_ok;

  // Next-state logic of the sequencer.
  always_comb begin
    next_st = st;
    next_st.fetch_start = 1'b0;
    unique case (st.state)
      crs_pkg::CRS_HOLD: begin
        // Wait for a usable supply before anything is driven.
        next_st.sys_reset_n = 1'b0;
        next_st.count = '0;
        if (COND.supply_ok) begin
          next_st.state = crs_pkg::CRS_WAIT;
          next_st.rstat = crs_pkg::RSTAT_ACTIVE;
        end
      end
      crs_pkg::CRS_WAIT: begin
        // Count only while all release conditions hold.
        next_st.sys_reset_n = 1'b0;
        next_st.rstat = crs_pkg::RSTAT_ACTIVE;
        if (any_src || !ready) begin
          next_st.count = '0;
        end else if (st.count == WAKE_LAST) begin
          // Release reset and hand the start address over.
          next_st.state = crs_pkg::CRS_RUN;
          next_st.sys_reset_n = 1'b1;
          next_st.fetch_addr = crs_pkg::FETCH_ADDR;
          next_st.fetch_start = 1'b1;
        end else begin
          next_st.count = st.count + CW'(1);
        end
      end
      crs_pkg::CRS_RUN: begin
        // Status goes high once brown-out has fully cleared.
        if (!bod_held) begin
          next_st.rstat = crs_pkg::RSTAT_IDLE;
        end
        if (any_src) begin
          // A new request restarts the whole sequence.
          next_st.state = crs_pkg::CRS_WAIT;
          next_st.sys_reset_n = 1'b0;
          next_st.rstat = crs_pkg::RSTAT_ACTIVE;
          next_st.count = '0;
        end
      end
      default: begin
        next_st.state = crs_pkg::CRS_HOLD;
      end
    endcase
    if (!COND.supply_ok) begin
      // Supply lost: fall back to holding.
      // The status pin follows internal reset down, so that the board
      // never sees status high while the core is held in reset.
      next_st.state = crs_pkg::CRS_HOLD;
      next_st.sys_reset_n = 1'b0;
      next_st.rstat = crs_pkg::RSTAT_ACTIVE;
      next_st.count = '0;
    end
  end

  // Register the state; all outputs take defined reset values.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st <= '{state: crs_pkg::CRS_HOLD, count: '0, sys_reset_n: 1'b0,
              rstat: crs_pkg::RSTAT_ACTIVE,
              fetch_addr: crs_pkg::FETCH_ADDR, fetch_start: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign SYS_RESET_N = st.sys_reset_n;
  assign RESET_STATUS_OUT = st.rstat;
  assign FETCH_ADDR = st.fetch_addr;
  assign FETCH_START = st.fetch_start;

  // A source in run state drops internal reset next cycle.
  src_drop_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (st.state == crs_pkg::CRS_RUN && any_src && COND.supply_ok)
      |=> !SYS_RESET_N)
    else $error("Reset source did not assert internal reset.");

  // Status is low whenever the sequencer is in the wait state.
  stat_low_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (st.state == crs_pkg::CRS_WAIT) |-> RESET_STATUS_OUT == 1'b0)
    else $error("Reset status high during reset.");

  // Release only with pin free, oscillator and flash ready.
  rel_cond_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    $rose(SYS_RESET_N) |-> $past(ready) && !$past(any_src))
    else $error("Reset released with a condition missing.");

  // Status stays low while brown-out filter is active.
  bod_stat_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    $rose(RESET_STATUS_OUT) |-> !$past(bod_held))
    else $error("Status rose before brown-out recovery.");

  // Fetch pulse coincides with release at address zero.
  fetch_zero_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    $rose(SYS_RESET_N) |-> FETCH_START &&
      FETCH_ADDR == crs_pkg::FETCH_ADDR)
    else $error("Fetch start missing at reset release.");

  // A supply that is no longer usable drops internal reset next cycle.
  // This guards the override at the end of the next-state logic, which
  // must win over every phase of the sequencer.
  supply_drop_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    !COND.supply_ok |=> !SYS_RESET_N)
    else $error("Internal reset released without usable supply.");

  // Status high is only ever seen while internal reset is released.
  // The status pin may lag the release but must never lead it.
  stat_rel_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    RESET_STATUS_OUT |-> SYS_RESET_N)
    else $error("Reset status high while internal reset held.");

  // The start address handed to the core never moves off zero.
  // A stray write to the register would send the core astray.
  addr_fixed_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    FETCH_ADDR == crs_pkg::FETCH_ADDR)
    else $error("Start address differs from address zero.");

  // Any source seen while waiting keeps internal reset asserted.
  // The count restarts too, so release can never follow at once.
  src_hold_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (st.state == crs_pkg::CRS_WAIT && any_src) |=> !SYS_RESET_N)
    else $error("Internal reset released with a source active.");

  // Timer restarts on any source reasserting while waiting.
  cnt_restart_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (st.state == crs_pkg::CRS_WAIT && any_src) |=> st.count == '0)
    else $error("Wake timer did not restart.");

  // Release needs the full count of quiet cycles.
  wake_len_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    $rose(SYS_RESET_N) |-> $past(st.count) == WAKE_LAST)
    else $error("Reset released before the wake count.");

  // Fetch pulse lasts one cycle only.
  fetch_one_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    FETCH_START |=> !FETCH_START)
    else $error("Fetch start longer than one cycle.");

endmodule

//--- core/crs_pkg.sv
// Package with constants and carrier types for the chip reset sequencer.
package crs_pkg;

  // Address where the processor starts fetching after reset release.
  localparam logic [31:0] FETCH_ADDR = 32'h0000_0000;

  // Default wake-up clock count once all other release conditions hold.
  localparam int WAKE_CYCLES_DEFAULT = 64;

  // Depth of the brown-out level filter in the small helper module.
  localparam int SYNC_STAGES = 2;

  // Reset-status pin level while reset is active and after release.
  localparam logic RSTAT_ACTIVE = 1'b0;
  localparam logic RSTAT_IDLE = 1'b1;

  // Reset source requests gathered together.
  typedef struct packed {
    logic pin;       // External reset pin, active.
    logic watchdog;  // Watchdog reset request.
    logic poweron;   // Power-on detector asserting.
    logic brownout;  // Brown-out detector asserting.
  } crs_src_t;

  // Release conditions that must all hold before the timer may finish.
  typedef struct packed {
    logic osc_ok;    // Oscillator running.
    logic flash_ok;  // Flash controller initialised.
    logic supply_ok; // Supply at a usable level.
  } crs_cond_t;

  // Sequencer states.
  typedef enum logic [1:0] {
    CRS_HOLD,
    CRS_WAIT,
    CRS_RUN
  } crs_state_t;

endpackage

//--- core/crs_hold_filter.sv
// Helper that stretches a brown-out indication for STAGES clock cycles after it clears.
`timescale 1ns/1ps

module crs_hold_filter #(
  parameter int STAGES = crs_pkg::SYNC_STAGES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic level_in,
  output logic held
);

  // All state of this module in one packed struct.
  typedef struct packed {
    logic [STAGES-1:0] pipe; // Shift line of recent brown-out samples.
    logic held;              // Any sample in the line was active.
  } crs_hf_t;

  crs_hf_t st;
  crs_hf_t next_st;

  // Refuse a line too short for the shift slice below.
  if (STAGES < 2) begin : g_chk
    $error("crs_hold_filter needs at least two stages.");
  end

  // Shift the level in and report any active sample.
  always_comb begin
    next_st = st;
    next_st.pipe = {st.pipe[STAGES-2:0], level_in};
    next_st.held = level_in | (|st.pipe);
  end

  // Register the state; brown-out assumed at reset.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{pipe: '1, held: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign held = st.held;

endmodule

//--- bench/crs_core_model.sv
// Processor core model that records each start of instruction fetch.
`timescale 1ns/1ps

module crs_core_model (
  input wire logic clk,
  input wire logic sys_reset_n,
  input wire logic fetch_start,
  input wire logic [31:0] fetch_addr
);
  // Last start address taken, poisoned until a start is seen.
  logic [31:0] start_addr = 32'hffff_ffff;
  int starts = 0; // Number of starts taken.

  // A start is taken only while internal reset is released.
  always @(posedge clk) begin
    if (fetch_start && sys_reset_n) begin
      start_addr <= fetch_addr;
      starts <= starts + 1;
    end
  end
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the chip reset sequencer.
`timescale 1ns/1ps

module tb_top;
  localparam int W = 4; // Short wake count keeps the run brief.
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  crs_pkg::crs_src_t src = '0;
  crs_pkg::crs_cond_t cond = '0;
  logic sys_n;
  logic stat;
  logic fst;
  logic [31:0] fa;
  int bad_count = 0;
  int cmp_count = 0;
  int rels = 0; // Releases seen, to match the core's start count.

  always #5 clk = ~clk;

  crs_sequencer #(.WAKE_CYCLES(W)) crs_sequencer_i (.CLK(clk),
    .ARST_N(arst_n), .SRC(src), .COND(cond), .SYS_RESET_N(sys_n),
    .RESET_STATUS_OUT(stat), .FETCH_ADDR(fa), .FETCH_START(fst));
  crs_core_model crs_core_model_i (.clk(clk), .sys_reset_n(sys_n),
    .fetch_start(fst), .fetch_addr(fa));

  // Compares one flag.
  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask

  // Compares one 32-bit value.
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Waits, bounded, for release and checks its delay and start pulse.
  task automatic rel();
    int n;
    n = 0;
    while (sys_n !== 1'b1 && n < W + 8) begin
      @(negedge clk);
      n++;
    end
    if (sys_n !== 1'b1) begin
      bad_count++;
      final_report();
    end
    chk1(n >= W && n <= W + 3, 1'b1);
    chk1(stat, 1'b0);
    chk1(fst, 1'b1);
    chk32(fa, 32'h0);
    rels++;
    repeat (2) @(negedge clk);
    chk1(fst, 1'b0);
    chk1(stat, 1'b1);
  endtask

  // Each missing condition, then the pin alone, keeps reset asserted.
  task automatic sc_block();
    logic [2:0] bl [3] = '{3'b011, 3'b101, 3'b110};
    for (int i = 0; i < 3; i++) begin
      cond = bl[i];
      repeat (2 * W + 4) @(negedge clk);
      chk1(sys_n, 1'b0);
      chk1(stat, 1'b0);
    end
    src.pin = 1'b1;
    cond = 3'b111;
    repeat (2 * W + 4) @(negedge clk);
    chk1(sys_n, 1'b0);
    src = '0;
    rel();
  endtask

  // Every source alone pulls reset and status low from the run state.
  task automatic sc_src();
    for (int i = 0; i < 4; i++) begin
      src = crs_pkg::crs_src_t'(4'h1 << i);
      repeat (2) @(negedge clk);
      chk1(sys_n, 1'b0);
      chk1(stat, 1'b0);
      src = '0;
      rel();
    end
  endtask

  // A watchdog blip late in the count must restart the whole count.
  task automatic sc_restart();
    src.watchdog = 1'b1;
    @(negedge clk);
    src = '0;
    repeat (W - 1) @(negedge clk);
    src.watchdog = 1'b1;
    @(negedge clk);
    src = '0;
    rel();
  endtask

  // Losing the supply in run holds reset and status until it returns.
  task automatic sc_supply();
    cond.supply_ok = 1'b0;
    repeat (2) @(negedge clk);
    chk1(sys_n, 1'b0);
    chk1(stat, 1'b0);
    chk1(fst, 1'b0);
    cond.supply_ok = 1'b1;
    rel();
  endtask

  // A reset in mid-run puts every output at its reset value.
  task automatic sc_arst();
    arst_n = 1'b0;
    @(negedge clk);
    chk1(sys_n, 1'b0);
    chk1(stat, 1'b0);
    chk1(fst, 1'b0);
    chk32(fa, 32'h0);
    arst_n = 1'b1;
    rel();
  endtask

  // Main sequence.
  initial begin
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    chk1(sys_n, 1'b0);
    sc_block();
    sc_src();
    sc_restart();
    sc_supply();
    sc_arst();
    chk32(crs_core_model_i.starts, rels);
    chk32(crs_core_model_i.start_addr, 32'h0);
    final_report();
  end
endmodule
